// ---- core/snmit_pkg.sv ----
// snmit_pkg: constants and carrier types of the two-wire memory target
// assumes: compiled before core/snmit_top.sv
`default_nettype none

package snmit_pkg;
	// array geometry
	localparam int ADDR_W = 17;
	localparam int MEM_WORDS = 131072;
	localparam int FIFO_DEPTH = 16;
	localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1ffff;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 17'h00001;
	// target address byte fields
	localparam logic [3:0] TYPE_CODE = 4'ha;
	localparam logic [3:0] ID_TYPE = 4'hf;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 2;
	localparam int PAGE_POS = 1;
	localparam int RW_POS = 0;
	// bit counter marks
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] CNT_STEP = 4'h1;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	// identification readout
	localparam logic [1:0] ID_BYTES = 2'h3;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	// bus rates served, and the bound on one scl half period at the fastest
	localparam int CLK_HZ = 25000000;
	localparam int STD_HZ = 100000;
	localparam int HS_HZ = 3400000;
	localparam int HS_HALF_CYC = CLK_HZ / (2 * HS_HZ);

	typedef enum logic [2:0] {
		S_IDLE, S_DEVADDR, S_ADDRHI, S_ADDRLO, S_WRITE, S_READ
	} snmit_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic sel_high;
		logic sel_low;
		logic wp;
	} snmit_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} snmit_wr_t;
endpackage

`default_nettype wire

// ---- core/snmit_top.sv ----
// snmit_top: two-wire target of a 128k x 8 nonvolatile memory, plus its write FIFO
// assumes: clk at 25 MHz; scl from the bus controller; pad resolves sda from sda_oe
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// write buffer between the bus engine and the array
module snmit_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic [AW:0] next_wr;
	logic [AW:0] next_rd;
	logic full;
	logic empty;

	// flags and pointer advance
	always_comb begin
		empty = (wr_ptr == rd_ptr);
		full = (wr_ptr == {~rd_ptr[AW], rd_ptr[AW-1:0]});
		in_ready = !full;
		out_valid = !empty;
		out_data = store[rd_ptr[AW-1:0]];
		next_wr = wr_ptr + {{AW{1'b0}}, in_valid && !full};
		next_rd = rd_ptr + {{AW{1'b0}}, !empty && out_ready};
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr;
			rd_ptr <= next_rd;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Contract
// - answer only when both select pins equal address byte bits 3 and 2; here identification type 1111 is answered with any select
// - select pins read as zero when left open; here there is no pull-down, only reset clears the synchronizers
// - sda is only pulled low or released, never driven high
// - data sampled on rising scl, output changed on falling scl
// - write protect high blocks every write; low allows all; default low; here wp has no pull-down, only reset clears its synchronizer
// - array of 131072 bytes, 17-bit address with page bit on top
// - address is target byte with page bit, then two address bytes
// - writes finish within the transfer, no busy time, no polling; here array_stall holds writes in the FIFO and a full FIFO refuses the byte
// - decode start, stop, data bit and acknowledge from sda and scl
// - serve 100 kHz, 400 kHz and up to 3.4 MHz bus clocks
// - hold a read-only identification value readable over the bus
// - address byte: type 1010 in 7-4, select 3-2, page 1, rw 0
// - start at any time aborts and readies; stop also aborts
// - address increments after each data byte, before ack, wraps 1ffff to 0
// - receiver pulls sda low after 8th bit; missing ack ends operation
module snmit_top #(
	// arbitrary identification value
	parameter logic [23:0] ID_VALUE = 24'h000001
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic device_select_pin_low,
	input wire logic device_select_pin_high,
	input wire logic write_protect,
	input wire logic array_stall
);
	import snmit_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// link side: scl clocks the bit sampler
	logic link_bit;
	logic link_tgl;
	logic next_link_bit;
	logic next_link_tgl;

	// capture sda on rising scl, flip the event toggle
	always_comb begin
		next_link_bit = sda_i;
		next_link_tgl = ~link_tgl;
	end

	always_ff @(posedge scl or posedge reset) begin
		if (reset) begin
			link_bit <= 1'b0;
			link_tgl <= 1'b0;
		end else begin
			link_bit <= next_link_bit;
			link_tgl <= next_link_tgl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossings: pins and the bit toggle through two flops each
	snmit_pins_t pins_m;
	snmit_pins_t pins_s;
	logic tgl_m;
	logic tgl_s;
	logic tgl_d;
	logic scl_d;
	logic sda_d;

	// synchronizers cleared to zero by reset, sda_d set to one, then follow the pins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pins_m <= '0;
			pins_s <= '0;
			tgl_m <= 1'b0;
			tgl_s <= 1'b0;
			tgl_d <= 1'b0;
			scl_d <= 1'b0;
			sda_d <= 1'b1;
		end else begin
			pins_m <= {scl, sda_i, device_select_pin_high, device_select_pin_low, write_protect};
			pins_s <= pins_m;
			tgl_m <= link_tgl;
			tgl_s <= tgl_m;
			tgl_d <= tgl_s;
			scl_d <= pins_s.scl;
			sda_d <= pins_s.sda;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus conditions; scl is only ever an input here
	logic bit_ev;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	// start, stop, bit and falling edge
	always_comb begin
		bit_ev = tgl_s ^ tgl_d;
		scl_fall = scl_d && !pins_s.scl;
		start_ev = pins_s.scl && scl_d && sda_d && !pins_s.sda;
		stop_ev = pins_s.scl && scl_d && !sda_d && pins_s.sda;
	end

	////////////////////////////////////////////////////////////////////////
	// array and write path
	logic [7:0] mem [MEM_WORDS];
	snmit_wr_t push_data;
	snmit_wr_t pop_data;
	logic push;
	logic push_ready;
	logic pop_valid;

	snmit_fifo #(
		.W($bits(snmit_wr_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(push),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(!array_stall),
		.out_data(pop_data)
	);

	// drain one byte a clock, far faster than a bus byte
	always_ff @(posedge clk) begin
		if (pop_valid && !array_stall) begin
			mem[pop_data.addr] <= pop_data.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus engine
	snmit_state_t state;
	snmit_state_t next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic [7:0] hi;
	logic [7:0] next_hi;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic page;
	logic next_page;
	logic ack;
	logic next_ack;
	logic idmode;
	logic next_idmode;
	logic [1:0] idx;
	logic [1:0] next_idx;
	logic next_oe;
	logic [7:0] byte_in;
	logic sel_ok;

	function automatic logic [7:0] id_byte(input logic [1:0] i);
		case (i)
			2'h0: id_byte = ID_VALUE[23:16];
			2'h1: id_byte = ID_VALUE[15:8];
			2'h2: id_byte = ID_VALUE[7:0];
			default: id_byte = FILL_BYTE;
		endcase
	endfunction

	// next values of the byte engine
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_sh = sh;
		next_tx = tx;
		next_hi = hi;
		next_addr = addr;
		next_page = page;
		next_ack = ack;
		next_idmode = idmode;
		next_idx = idx;
		next_oe = sda_oe;
		push = 1'b0;
		byte_in = {sh[6:0], link_bit};
		sel_ok = (byte_in[SEL_MSB:SEL_LSB] == {pins_s.sel_high, pins_s.sel_low});
		push_data.addr = addr;
		push_data.data = byte_in;
		if (start_ev) begin
			next_state = S_DEVADDR;
			next_cnt = CNT_RST;
			next_ack = 1'b0;
			next_oe = 1'b0;
		end else if (stop_ev) begin
			next_state = S_IDLE;
			next_ack = 1'b0;
			next_oe = 1'b0;
		end else begin
			if (bit_ev && state != S_IDLE) begin
				if (cnt == BIT_ACK) begin
					next_cnt = CNT_RST;
					next_ack = 1'b0;
					if (state == S_READ) begin
						if (link_bit) begin
							next_state = S_IDLE;
						end else if (idmode) begin
							next_tx = id_byte(idx);
							next_idx = (idx == ID_BYTES) ? idx : idx + 2'h1;
						end else begin
							next_tx = mem[addr];
						end
					end
				end else begin
					next_sh = byte_in;
					next_cnt = cnt + CNT_STEP;
					if (cnt == BIT_LAST) begin
						unique case (state)
							S_IDLE: begin
							end
							S_DEVADDR: begin
								if (byte_in[TYPE_MSB:TYPE_LSB] == TYPE_CODE && sel_ok) begin
									next_ack = 1'b1;
									next_idmode = 1'b0;
									if (byte_in[RW_POS]) begin
										next_state = S_READ;
										next_tx = mem[addr];
									end else begin
										next_page = byte_in[PAGE_POS];
										next_state = S_ADDRHI;
									end
								end else if (byte_in[TYPE_MSB:TYPE_LSB] == ID_TYPE && byte_in[RW_POS]) begin
									next_ack = 1'b1;
									next_idmode = 1'b1;
									// own ack on the 9th clock loads byte 0 again
									next_idx = 2'h0;
									next_tx = id_byte(2'h0);
									next_state = S_READ;
								end else begin
									next_state = S_IDLE;
								end
							end
							S_ADDRHI: begin
								next_hi = byte_in;
								next_ack = 1'b1;
								next_state = S_ADDRLO;
							end
							S_ADDRLO: begin
								next_addr = {page, hi, byte_in};
								next_ack = 1'b1;
								next_state = S_WRITE;
							end
							S_WRITE: begin
								if (!pins_s.wp && push_ready) begin
									push = 1'b1;
									next_ack = 1'b1;
									next_addr = addr + ADDR_STEP;
								end else begin
									next_state = S_IDLE;
								end
							end
							S_READ: begin
								if (!idmode) begin
									next_addr = addr + ADDR_STEP;
								end
							end
						endcase
					end
				end
			end
			if (scl_fall) begin
				if (ack) begin
					next_oe = 1'b1;
				end else if (state == S_READ && cnt != BIT_ACK) begin
					next_oe = ~tx[3'h7 - cnt[2:0]];
				end else begin
					next_oe = 1'b0;
				end
			end
		end
	end

	// engine registers; sda only ever pulled low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= S_IDLE;
			cnt <= CNT_RST;
			sh <= 8'h00;
			tx <= 8'h00;
			hi <= 8'h00;
			addr <= ADDR_RST;
			page <= 1'b0;
			ack <= 1'b0;
			idmode <= 1'b0;
			idx <= 2'h0;
			sda_oe <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sh <= next_sh;
			tx <= next_tx;
			hi <= next_hi;
			addr <= next_addr;
			page <= next_page;
			ack <= next_ack;
			idmode <= next_idmode;
			idx <= next_idx;
			sda_oe <= next_oe;
			sda_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	localparam int HALF_MAX = 400;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_last_bit;
		bit_ev && cnt == BIT_LAST && state != S_IDLE && !start_ev && !stop_ev;
	endsequence

	sequence s_acked;
		s_last_bit ##1 ack;
	endsequence

	AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
		else $error("sda output value not low");
	AST_START_ABORT: assert property (start_ev |=> state == S_DEVADDR && cnt == CNT_RST && !sda_oe)
		else $error("start did not ready the engine");
	AST_STOP_ABORT: assert property (stop_ev |=> state == S_IDLE && !sda_oe)
		else $error("stop did not end the operation");
	AST_OE_ON_FALL: assert property ($rose(sda_oe) |-> $past(scl_fall))
		else $error("sda pulled low away from falling scl");
	AST_SELECT_MATCH: assert property (s_last_bit and (state == S_DEVADDR
		&& byte_in[TYPE_MSB:TYPE_LSB] == TYPE_CODE && !sel_ok) |=> !ack && state == S_IDLE)
		else $error("answered a foreign select code");
	AST_QUIET_IDLE: assert property (state == S_IDLE && $past(state) == S_IDLE |-> !sda_oe)
		else $error("sda pulled while not addressed");
	AST_WP_REFUSE: assert property (s_last_bit and (state == S_WRITE && pins_s.wp)
		|=> !ack && state == S_IDLE && $stable(addr))
		else $error("protected write accepted");
	AST_ADDR_WRAP: assert property (push && addr == ADDR_LAST |=> addr == ADDR_RST)
		else $error("address did not wrap");
	AST_ACK_DRIVEN: assert property (s_acked |-> ##[0:HALF_MAX] (sda_oe || start_ev || stop_ev))
		else $error("acknowledge never driven");
	AST_WRITE_QUEUED: assert property (push |-> push_ready && !pins_s.wp ##1 pop_valid)
		else $error("accepted write not queued");
endmodule

`default_nettype wire

// ---- test/snmit_ctrl.sv ----
// snmit_ctrl: two-wire bus controller model, makes scl and pulls sda low
// assumes: the bench resolves sda from pull_low and the target's enable
`default_nettype none
////////////////////////////////////////
module snmit_ctrl #(
	parameter int HALF = 200
) (
	output logic scl,
	output logic pull_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int Q = HALF / 4;
	// idle bus: scl parked high, sda released
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// one scl pulse, sda taken late in the high phase
	task automatic pulse(output logic s);
		#HALF scl = 1'b1;
		#HALF s = sda;
		scl = 1'b0;
	endtask
	// sda falls while scl high
	task automatic start();
		#Q pull_low = 1'b0;
		#HALF scl = 1'b1;
		#HALF pull_low = 1'b1;
		#HALF scl = 1'b0;
	endtask
	// sda rises while scl high, scl then stands still
	task automatic stop();
		#Q pull_low = 1'b1;
		#HALF scl = 1'b1;
		#HALF pull_low = 1'b0;
		#HALF;
	endtask
	// first n bits of a byte, msb first
	task automatic part(input logic [7:0] b, input int n);
		logic s;
		for (int i = 7; i > 7 - n; i--) begin
			#Q pull_low = ~b[i];
			pulse(s);
		end
	endtask
	// whole byte, then the target's ack sampled
	task automatic send(input logic [7:0] b, output logic [7:0] ack);
		logic s;
		part(b, 8);
		#Q pull_low = 1'b0;
		pulse(s);
		ack = {7'h00, ~s};
	endtask
	// byte from the target, then ack or nack
	task automatic recv(input logic ack, output logic [7:0] b);
		logic s;
		#Q pull_low = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			pulse(s);
			b[i] = s;
		end
		#Q pull_low = ack;
		pulse(s);
	endtask
endmodule
`default_nettype wire

// ---- test/serial_nv_memory_i2c_target_bench.sv ----
// serial_nv_memory_i2c_target_bench: self-checking bench of the memory target
// assumes: snmit_pkg, snmit_top and snmit_ctrl compiled first
`default_nettype none
////////////////////////////////////////
module serial_nv_memory_i2c_target_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import snmit_pkg::*;
	localparam logic [23:0] TEST_ID = 24'h5a1c3e; // arbitrary value
	localparam logic [1:0] SEL = 2'h2;
	logic clk, reset, sda_o, sda_oe, sel_low, sel_high, wp, stall;
	wire scl, pull_low, sda;
	int errors, n_checks;
	// wired and with an external pull-up
	assign sda = ~(pull_low | (sda_oe & ~sda_o));
	snmit_top #(.ID_VALUE(TEST_ID)) dut (.clk(clk), .reset(reset), .scl(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.device_select_pin_low(sel_low), .device_select_pin_high(sel_high),
		.write_protect(wp), .array_stall(stall));
	// scl half period kept at five system clocks
	snmit_ctrl #(.HALF(200)) ctrl (.scl(scl), .pull_low(pull_low), .sda(sda));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic pins(input logic w, input logic s);
		@(posedge clk);
		#2;
		wp = w;
		stall = s;
	endtask
	// write header: address byte, high and low address bytes
	task automatic open_at(input logic [16:0] a);
		logic [7:0] k;
		ctrl.start();
		ctrl.send({TYPE_CODE, SEL, a[16], 1'b0}, k);
		check(k, 8'h01);
		ctrl.send(a[15:8], k);
		check(k, 8'h01);
		ctrl.send(a[7:0], k);
		check(k, 8'h01);
	endtask
	task automatic rd_open();
		logic [7:0] k;
		ctrl.start();
		ctrl.send({TYPE_CODE, SEL, 2'h1}, k);
		check(k, 8'h01);
	endtask
	// fill the buffer with the array stalled, then read back across the wrap
	task automatic t_fifo_wrap();
		logic [7:0] k;
		logic [7:0] d;
		pins(1'b0, 1'b1);
		open_at(17'h1fff8);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			ctrl.send(8'ha0 + 8'(i), k);
			check(k, 8'h01);
		end
		ctrl.send(8'h77, k);
		check(k, 8'h00); // full buffer refuses
		ctrl.stop();
		pins(1'b0, 1'b0);
		open_at(17'h1fff8);
		rd_open();
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			ctrl.recv(i != FIFO_DEPTH - 1, d);
			check(d, 8'ha0 + 8'(i));
		end
		ctrl.stop();
	endtask
	// four select codes and one foreign type code
	task automatic t_select();
		logic [7:0] k;
		logic [7:0] d;
		logic [3:0] code;
		for (int s = 0; s < 5; s++) begin
			code = (s == 4) ? 4'hb : TYPE_CODE;
			ctrl.start();
			ctrl.send({code, 2'(s), 2'h1}, k);
			check(k, {7'h00, s == int'(SEL)});
			if (k[0]) begin
				ctrl.recv(1'b0, d);
			end else begin
				ctrl.send(8'h00, k);
				check(k, 8'h00);
			end
			ctrl.stop();
		end
	endtask
	// refused byte leaves data and latch alone
	task automatic t_protect();
		logic [7:0] k;
		logic [7:0] d;
		open_at(17'h00003);
		ctrl.send(8'hab, k);
		check(k, 8'h01);
		ctrl.stop();
		pins(1'b1, 1'b0);
		open_at(17'h00003);
		ctrl.send(8'h55, k);
		check(k, 8'h00);
		rd_open();
		ctrl.recv(1'b0, d);
		check(d, 8'hab);
		ctrl.stop();
		pins(1'b0, 1'b0);
	endtask
	// stop clocked in place of the seventh data bit leaves the byte alone
	task automatic t_abort();
		logic [7:0] k;
		logic [7:0] d;
		open_at(17'h00005);
		ctrl.send(8'had, k);
		check(k, 8'h01);
		ctrl.stop();
		open_at(17'h00005);
		ctrl.part(8'h00, 6);
		ctrl.stop();
		open_at(17'h00005);
		rd_open();
		ctrl.recv(1'b0, d);
		check(d, 8'had);
		ctrl.stop();
	endtask
	// identification readout, select bits ignored
	task automatic t_id();
		logic [7:0] k;
		logic [7:0] d;
		ctrl.start();
		ctrl.send({ID_TYPE, 2'h1, 2'h1}, k);
		check(k, 8'h01);
		for (int i = 0; i < 4; i++) begin
			ctrl.recv(i < 3, d);
			check(d, i < 3 ? TEST_ID[23 - 8 * i -: 8] : FILL_BYTE);
		end
		ctrl.stop();
	endtask
	// main sequence
	initial begin
		errors = 0;
		n_checks = 0;
		reset = 1'b1;
		sel_low = 1'b0;
		sel_high = 1'b1;
		wp = 1'b0;
		stall = 1'b0;
		repeat (12) @(posedge clk);
		#2 reset = 1'b0;
		repeat (4) @(posedge clk);
		t_fifo_wrap();
		t_select();
		t_protect();
		t_abort();
		t_id();
		summarize();
	end
	// watchdog
	initial begin
		#2000000;
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
